// ==== hdl/chg_pkg.sv ====
// Contract
// - Filter supply glitches; start above UVLO rising
// - Below precharge threshold deliver pre-charge current
// - Between thresholds run constant-current fast charge
// - At regulation voltage switch to constant voltage
// - Charge-active indicator follows current above termination
// - Timer on: float in CV until expiry, monitor
// - Timer off: stop at termination current
// - Monitor: output off, recharge clears timer
// - Pre-charge beyond quarter time is a fault
// - Pre-charge fault clears by supply cycle, voltage
// - Timer pin selects internal, disabled or resistor
// - Resistor time is ohms over three seconds
// - Temperature out of window suspends, pauses, faults
// - Hot and cold thresholds both have hysteresis
// - Back inside window resumes with paused timer
// - Only output-on time counts toward time-out
// - Window hot to cold offset, default if grounded
// - Current reference fixed or host-driven analog voltage
// - Below disable level reset timer, no fault
// - Supply-present indicator low while above UVLO
package chg_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS   = 32'h0000_0004;     // 250 MHz core clock
  localparam int TICK_PERIOD_NS  = 32'h3B9A_CA00;     // One timer tick is one second
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int GLITCH_NS       = 32'h0000_03E8;     // Supply must be stable this long
  localparam int GLITCH_CYCLES   = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Charge timer figures, in seconds
  localparam int SEC_PER_HOUR    = 32'h0000_0E10;
  localparam int INTERNAL_HOURS  = 32'h0000_0003;
  localparam int INTERNAL_TIME_S = INTERNAL_HOURS * SEC_PER_HOUR;
  localparam int MIN_TIME_S      = 32'h0000_0002 * SEC_PER_HOUR;
  localparam int MAX_TIME_S      = 32'h0000_0006 * SEC_PER_HOUR;
  localparam int TIMER_PROGRAM_PIN_DIVISOR    = 32'h0000_0003;
  localparam int PRE_LIMIT_SHIFT = 32'h0000_0002;     // Quarter of total time
  localparam int TIMER_W         = 32'h0000_0010;
  localparam int TIMER_PROGRAM_PIN_OHMS_W     = 32'h0000_0010;

  // Register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIMER  = 8'h08;
  localparam logic [7:0] REG_LIMIT  = 8'h0C;
  localparam int CTRL_RUN_BIT       = 32'h0000_0000;
  localparam logic CTRL_RUN_RESET   = 1'h1;
  localparam int STS_STATE_LSB      = 32'h0000_0000;
  localparam int STS_OUT_ON_BIT     = 32'h0000_0004;
  localparam int STS_TFAULT_BIT     = 32'h0000_0005;
  localparam int STS_PFAULT_BIT     = 32'h0000_0006;
  localparam int STS_VCC_OK_BIT     = 32'h0000_0007;
  localparam int STS_CHG_ACT_BIT    = 32'h0000_0008;
  localparam int STS_AFC_BIT        = 32'h0000_0009;
  localparam int STS_TIM_EN_BIT     = 32'h0000_000A;
  localparam int STS_DISABLE_BIT    = 32'h0000_000B;

  // Charge sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PRE,
    ST_CC,
    ST_CV,
    ST_MON,
    ST_PFAULT
  } state_t;

  // Comparator and strap levels from the analog side
  typedef struct packed {
    logic vcc_uvlo_ok;        // Supply above lockout
    logic bat_above_preq;     // Battery above pre-charge threshold
    logic bat_at_cv;          // Battery at regulation voltage
    logic bat_below_rechg;    // Battery below regulation minus recharge drop
    logic iout_above_term;    // Output current above termination
    logic ntc_disable;        // Sense below disable level
    logic hot_trip;           // Sense below hot threshold
    logic hot_release;        // Sense above hot threshold plus hysteresis
    logic cold_trip;          // Sense above offset cold threshold
    logic cold_release;       // Sense below offset cold threshold minus hysteresis
    logic cold_dflt_trip;     // Sense above default cold threshold
    logic cold_dflt_release;  // Sense below default cold threshold minus hysteresis
    logic cto_grounded;       // Cold offset input tied low
    logic afc_at_vcc;         // Analog current input tied to supply
    logic timer_program_pin_at_vcc;        // Timer pin tied to supply
    logic timer_program_pin_at_gnd;        // Timer pin tied low
  } cmp_t;

  typedef struct packed {
    cmp_t                   cmp;
    logic [TIMER_PROGRAM_PIN_OHMS_W-1:0] timer_program_pin_ohms;  // Measured timer resistor in ohms
  } pins_t;

  // Analog control outputs
  typedef struct packed {
    logic out_on;        // Pass transistor enabled
    logic pre_current;   // Reduced pre-charge current selected
    logic cv_mode;       // Voltage loop in control
    logic ref_use_afc;   // Fast-charge reference from analog input
  } drive_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage

// ==== hdl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_q
);

  // Three stages; the output moves only where stages two and three agree
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t r_r;    // Registered state
  sync_state_t r_nxt;  // Next state

  if (W < 1) begin : g_chk
    $error("pin_sync width must be positive");
  end

  // Shift and accept agreeing bits; s1 feeds only s2
  always_comb
  begin
    r_nxt    = r_r;
    r_nxt.s1 = i_pin;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (r_r.s2[i] == r_r.s3[i])
      begin
        r_nxt.q[i] = r_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign o_q = r_r.q;

endmodule // pin_sync

// ==== hdl/liion_charge_sequencer.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module liion_charge_sequencer #(
  parameter int TICK_CYCLES   = chg_pkg::TICK_CYCLES,    // Cycles per timer tick
  parameter int GLITCH_CYCLES = chg_pkg::GLITCH_CYCLES   // Supply stability filter
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire chg_pkg::pins_t   i_pins,
  input  wire chg_pkg::bus_req_t i_bus,
  output logic [31:0]           o_rdata,
  output chg_pkg::drive_t       o_drive,
  output logic                  o_charge_active_n,
  output logic                  o_charge_active_oe,
  output logic                  o_fault_n,
  output logic                  o_fault_oe,
  output logic                  o_supply_present_n,
  output logic                  o_supply_present_oe
);

  localparam int PW = $bits(chg_pkg::pins_t);
  localparam int TW = chg_pkg::TIMER_W;
  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int GW = (GLITCH_CYCLES > 1) ? $clog2(GLITCH_CYCLES) + 1 : 1;
  localparam logic [CW-1:0] TICK_LAST   = CW'(TICK_CYCLES - 1);
  localparam logic [GW-1:0] GLITCH_LAST = GW'(GLITCH_CYCLES - 1);

  // Refuse settings the counters cannot serve
  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (GLITCH_CYCLES < 1) begin : g_chk_glitch
    $error("GLITCH_CYCLES must be at least 1");
  end
  if (chg_pkg::MAX_TIME_S >= (1 << TW)) begin : g_chk_tw
    $error("Timer width too small for longest charge time");
  end

  // Whole state of the sequencer
  typedef struct packed {
    chg_pkg::state_t st;          // Charge mode
    logic [GW-1:0]   glt_cnt;     // Supply stability counter
    logic            vcc_ok;      // Filtered supply level
    logic [CW-1:0]   pre_cnt;     // Prescaler toward one tick
    logic [TW-1:0]   timer;       // Elapsed output-on seconds
    logic [TW-1:0]   limit;       // Total charge time in seconds
    logic            tim_en;      // Timer in use
    logic            hot_flt;     // Hot side latched with hysteresis
    logic            cold_flt;    // Cold side latched with hysteresis
    logic            run;         // Software run enable
    logic [31:0]     rdata;       // Read answer
    chg_pkg::drive_t drive;       // Analog control outputs
    logic            chg_act;     // Charge-active indicator driving
    logic            flt_act;     // Fault indicator driving
    logic            sup_act;     // Supply-present indicator driving
  } seq_state_t;

  seq_state_t     r_r;            // Registered state
  seq_state_t     r_nxt;          // Next state
  chg_pkg::pins_t pins_s;         // Synchronized comparator levels
  chg_pkg::cmp_t  cmp;            // Comparator part of the above

  // Every analog decision enters through the synchronizer
  pin_sync #(
    .W (PW)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_pins),
    .o_q     (pins_s)
  );

  assign cmp = pins_s.cmp;

  // Charge time from the timer pin strapping, clamped to the usable range
  function automatic logic [TW-1:0] calc_limit(input logic at_vcc,
                                               input logic [chg_pkg::TIMER_PROGRAM_PIN_OHMS_W-1:0] ohms);
    logic [TW-1:0] t;
    t = TW'(ohms / chg_pkg::TIMER_PROGRAM_PIN_DIVISOR);
    if (at_vcc)
    begin
      t = TW'(chg_pkg::INTERNAL_TIME_S);
    end
    else if (t < TW'(chg_pkg::MIN_TIME_S))
    begin
      t = TW'(chg_pkg::MIN_TIME_S);
    end
    else if (t > TW'(chg_pkg::MAX_TIME_S))
    begin
      t = TW'(chg_pkg::MAX_TIME_S);
    end
    return t;
  endfunction

  // States in which the pass transistor may conduct
  function automatic logic is_charging(input chg_pkg::state_t s);
    return (s == chg_pkg::ST_PRE) || (s == chg_pkg::ST_CC) || (s == chg_pkg::ST_CV);
  endfunction

  // Next-state logic for the whole block
  always_comb
  begin
    logic tick;          // One-second pulse
    logic tfault;        // Temperature outside window
    logic cold_trip;     // Selected cold comparator
    logic cold_rel;      // Selected cold release comparator
    logic disabled;      // Device held off by supply, sense pin or software
    logic out_on;        // Conducting this cycle
    logic expired;       // Timer has reached the limit
    logic pre_over;      // Pre-charge has used its quarter
    tick      = 1'b0;
    tfault    = 1'b0;
    cold_trip = 1'b0;
    cold_rel  = 1'b0;
    disabled  = 1'b0;
    out_on    = 1'b0;
    expired   = 1'b0;
    pre_over  = 1'b0;
    r_nxt     = r_r;

    // Supply glitch filter: a change must persist before it is believed
    if (cmp.vcc_uvlo_ok != r_r.vcc_ok)
    begin
      if (r_r.glt_cnt >= GLITCH_LAST)
      begin
        r_nxt.vcc_ok  = cmp.vcc_uvlo_ok;
        r_nxt.glt_cnt = '0;
      end
      else
      begin
        r_nxt.glt_cnt = r_r.glt_cnt + GW'(1);
      end
    end
    else
    begin
      r_nxt.glt_cnt = '0;                                  // Glitch rejected
    end

    // Cold threshold from the offset input unless it is grounded
    cold_trip = cmp.cto_grounded ? cmp.cold_dflt_trip : cmp.cold_trip;
    cold_rel  = cmp.cto_grounded ? cmp.cold_dflt_release : cmp.cold_release;

    // Hysteretic fault latches; a trip outranks a release
    if (cmp.hot_trip)
    begin
      r_nxt.hot_flt = 1'b1;
    end
    else if (cmp.hot_release)
    begin
      r_nxt.hot_flt = 1'b0;
    end
    if (cold_trip)
    begin
      r_nxt.cold_flt = 1'b1;
    end
    else if (cold_rel)
    begin
      r_nxt.cold_flt = 1'b0;
    end

    // Disable level also reads as below hot; it must not show a fault
    if (cmp.ntc_disable)
    begin
      r_nxt.hot_flt  = 1'b0;
      r_nxt.cold_flt = 1'b0;
    end
    tfault = r_r.hot_flt || r_r.cold_flt;

    disabled = !r_r.vcc_ok || cmp.ntc_disable || !r_r.run;
    out_on   = is_charging(r_r.st) && !tfault && !disabled;

    // Prescaler runs only while conducting, so suspended time is not counted
    if (out_on)
    begin
      if (r_r.pre_cnt >= TICK_LAST)
      begin
        r_nxt.pre_cnt = '0;
        tick          = 1'b1;
      end
      else
      begin
        r_nxt.pre_cnt = r_r.pre_cnt + CW'(1);
      end
    end
    if (tick && r_r.tim_en && (r_r.timer < r_r.limit))
    begin
      r_nxt.timer = r_r.timer + TW'(1);
    end

    expired  = r_r.tim_en && (r_r.timer >= r_r.limit);
    pre_over = r_r.tim_en && (r_r.timer >= (r_r.limit >> chg_pkg::PRE_LIMIT_SHIFT));

    // Charge mode sequencing
    if (disabled)
    begin
      // Supply loss, sense pin reset or software stop: start over later
      r_nxt.st      = chg_pkg::ST_OFF;
      r_nxt.timer   = '0;
      r_nxt.pre_cnt = '0;
    end
    else
    begin
      case (r_r.st)
        chg_pkg::ST_OFF:
        begin
          // Supply qualified: capture timer strapping and begin
          r_nxt.tim_en = !cmp.timer_program_pin_at_gnd;
          r_nxt.limit  = calc_limit(cmp.timer_program_pin_at_vcc, pins_s.timer_program_pin_ohms);
          r_nxt.st     = chg_pkg::ST_PRE;
        end
        chg_pkg::ST_PRE:
        begin
          if (cmp.bat_above_preq)
          begin
            r_nxt.st = chg_pkg::ST_CC;
          end
          else if (pre_over && !tfault)
          begin
            r_nxt.st = chg_pkg::ST_PFAULT;
          end
        end
        chg_pkg::ST_CC:
        begin
          if (expired)
          begin
            r_nxt.st = chg_pkg::ST_MON;                    // Time-out in CC and CV; pre-charge faults at its quarter first
          end
          else if (cmp.bat_at_cv)
          begin
            r_nxt.st = chg_pkg::ST_CV;
          end
          else if (!cmp.bat_above_preq)
          begin
            r_nxt.st = chg_pkg::ST_PRE;
          end
        end
        chg_pkg::ST_CV:
        begin
          // With the timer on, termination only releases the indicator
          if (r_r.tim_en)
          begin
            if (expired)
            begin
              r_nxt.st = chg_pkg::ST_MON;
            end
          end
          else if (!cmp.iout_above_term && !tfault)
          begin
            r_nxt.st = chg_pkg::ST_MON;
          end
        end
        chg_pkg::ST_MON:
        begin
          if (cmp.bat_below_rechg)
          begin
            r_nxt.timer   = '0;
            r_nxt.pre_cnt = '0;
            r_nxt.st      = chg_pkg::ST_PRE;
          end
        end
        chg_pkg::ST_PFAULT:
        begin
          // Latched until supply cycles, the sense pin or software disables, or the battery rises
          if (cmp.bat_above_preq)
          begin
            r_nxt.st = chg_pkg::ST_CC;
          end
        end
        default:
        begin
          r_nxt.st = chg_pkg::ST_OFF;
        end
      endcase
    end

    // Analog drive, registered so the pass device never sees a decode glitch
    r_nxt.drive.out_on      = out_on;
    r_nxt.drive.pre_current = out_on && (r_r.st == chg_pkg::ST_PRE);
    r_nxt.drive.cv_mode     = out_on && (r_r.st == chg_pkg::ST_CV);
    r_nxt.drive.ref_use_afc = !cmp.afc_at_vcc;

    // Open-drain indicators; "act" means the pin is pulled low
    r_nxt.chg_act = out_on && cmp.iout_above_term;
    r_nxt.flt_act = !disabled && (tfault || (r_r.st == chg_pkg::ST_PFAULT));
    r_nxt.sup_act = r_r.vcc_ok;

    // Register port: writes take effect on the next edge
    if (i_bus.wr && (i_bus.addr == chg_pkg::REG_CTRL))
    begin
      r_nxt.run = i_bus.wdata[chg_pkg::CTRL_RUN_BIT];
    end

    // Read answer stands for the cycle after the strobe only
    r_nxt.rdata = '0;
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        chg_pkg::REG_CTRL:
        begin
          r_nxt.rdata[chg_pkg::CTRL_RUN_BIT] = r_r.run;
        end
        chg_pkg::REG_STATUS:
        begin
          r_nxt.rdata[chg_pkg::STS_STATE_LSB +: $bits(chg_pkg::state_t)] = r_r.st;
          r_nxt.rdata[chg_pkg::STS_OUT_ON_BIT]     = r_r.drive.out_on;
          r_nxt.rdata[chg_pkg::STS_TFAULT_BIT]     = tfault;
          r_nxt.rdata[chg_pkg::STS_PFAULT_BIT]     = (r_r.st == chg_pkg::ST_PFAULT);
          r_nxt.rdata[chg_pkg::STS_VCC_OK_BIT]     = r_r.vcc_ok;
          r_nxt.rdata[chg_pkg::STS_CHG_ACT_BIT]    = r_r.chg_act;
          r_nxt.rdata[chg_pkg::STS_AFC_BIT]        = r_r.drive.ref_use_afc;
          r_nxt.rdata[chg_pkg::STS_TIM_EN_BIT]     = r_r.tim_en;
          r_nxt.rdata[chg_pkg::STS_DISABLE_BIT]    = cmp.ntc_disable;
        end
        chg_pkg::REG_TIMER:
        begin
          r_nxt.rdata[TW-1:0] = r_r.timer;
        end
        chg_pkg::REG_LIMIT:
        begin
          r_nxt.rdata[TW-1:0] = r_r.limit;
        end
        default:
        begin
          r_nxt.rdata = '0;                                // Unmapped reads zero
        end
      endcase
    end
  end

  // State register; reset leaves the output off and software run enabled
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_r       <= '0;
      r_r.st    <= chg_pkg::ST_OFF;
      r_r.run   <= chg_pkg::CTRL_RUN_RESET;
      r_r.limit <= TW'(chg_pkg::INTERNAL_TIME_S);
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Outputs from flip-flops; the open-drain levels are tied low
  assign o_rdata             = r_r.rdata;
  assign o_drive             = r_r.drive;
  assign o_charge_active_n   = 1'b0;
  assign o_charge_active_oe  = r_r.chg_act;
  assign o_fault_n           = 1'b0;
  assign o_fault_oe          = r_r.flt_act;
  assign o_supply_present_n  = 1'b0;
  assign o_supply_present_oe = r_r.sup_act;

endmodule // liion_charge_sequencer

// ==== testbench/chg_seq_properties.sv ====
`timescale 1ns/10ps
module chg_seq_properties #(
  parameter int TICK_CYCLES   = 10,
  parameter int GLITCH_CYCLES = 4
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire chg_pkg::pins_t    i_pins,
  input wire chg_pkg::bus_req_t i_bus,
  input wire logic [31:0]       o_rdata,
  input wire chg_pkg::drive_t   o_drive,
  input wire logic              o_charge_active_n,
  input wire logic              o_charge_active_oe,
  input wire logic              o_fault_n,
  input wire logic              o_fault_oe,
  input wire logic              o_supply_present_n,
  input wire logic              o_supply_present_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [4:0] low_cnt_r;  // Cycles of supply below lockout, saturating
  // Long enough to cover pin sync plus the glitch filter
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) low_cnt_r <= 5'h00;
    else if (i_pins.cmp.vcc_uvlo_ok) low_cnt_r <= 5'h00;
    else if (low_cnt_r != 5'h1F) low_cnt_r <= low_cnt_r + 5'h01;
  a_supply_lost_off: assert property (low_cnt_r >= 5'h10 |->
    !o_supply_present_oe && !o_drive.out_on) else $error("supply lost but still on");
  a_pins_drive_low: assert property (!o_fault_n && !o_charge_active_n
    && !o_supply_present_n) else $error("open-drain level not low");
  a_rdata_idle_zero: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_pre_not_cv: assert property (o_drive.pre_current |-> !o_drive.cv_mode)
    else $error("pre-charge and voltage loop together");
  a_active_needs_out: assert property (o_charge_active_oe |->
    o_drive.out_on || $past(o_drive.out_on)) else $error("charge active while off");
  a_hot_trip_suspend: assert property ((i_pins.cmp.hot_trip && o_supply_present_oe
    && !i_pins.cmp.ntc_disable) [*8] |-> !o_drive.out_on && o_fault_oe)
    else $error("hot trip did not suspend");
  a_cold_default_trip: assert property ((i_pins.cmp.cto_grounded
    && i_pins.cmp.cold_dflt_trip && !i_pins.cmp.ntc_disable) [*8] |-> !o_drive.out_on)
    else $error("default cold trip ignored");
  a_disable_no_fault: assert property ((i_pins.cmp.ntc_disable && !i_pins.cmp.hot_trip
    && !i_pins.cmp.cold_trip && !i_pins.cmp.cold_dflt_trip) [*8]
    |-> !o_drive.out_on && !o_fault_oe) else $error("disable left output or fault");
  a_afc_fixed_ref: assert property (i_pins.cmp.afc_at_vcc [*8] |->
    !o_drive.ref_use_afc) else $error("fixed reference not used");
  c_out_on: cover property ($rose(o_drive.out_on));
  c_cv_mode: cover property ($rose(o_drive.cv_mode));
  c_fault: cover property ($rose(o_fault_oe));
  c_active: cover property ($fell(o_charge_active_oe));
endmodule // chg_seq_properties

// ==== testbench/batt_pack_model.sv ====
`timescale 1ns/10ps
module batt_pack_model (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire chg_pkg::cmp_t   i_cmd,    // Pack, thermistor and host levels
  input  wire logic [15:0]     i_ohms,   // Timer resistor value
  input  wire chg_pkg::drive_t i_drive,
  output chg_pkg::pins_t       o_pins
);
  chg_pkg::cmp_t lvl;  // Levels as the pins will show them

  // Current only flows through an enabled pass device
  always_comb
  begin
    lvl                 = i_cmd;
    lvl.iout_above_term = i_cmd.iout_above_term & i_drive.out_on;
  end

  // Levels step on the clock edge, one write per field
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pins <= '0;
    end
    else
    begin
      o_pins.cmp       <= lvl;
      o_pins.timer_program_pin_ohms <= i_ohms;
    end
  end
endmodule // batt_pack_model

// ==== testbench/liion_charge_sequencer_bench.sv ====
`timescale 1ns/10ps
module liion_charge_sequencer_bench;
  localparam int TK = 2;  // Short tick keeps the three-hour count inside the run
  logic              clk;
  logic              rst_n;
  chg_pkg::cmp_t     cmd;     // Levels asked of the pack model
  logic [15:0]       ohms;
  chg_pkg::pins_t    pins;
  chg_pkg::bus_req_t bus;
  logic [31:0]       rdata;
  chg_pkg::drive_t   drv;
  logic              act_oe;
  logic              flt_oe;
  logic              sup_oe;
  logic [31:0]       exp_q[$];  // Expected read words, oldest first
  logic [31:0]       msk_q[$];
  logic              rd_d = 1'b0;
  logic [15:0]       lfsr;
  int                mismatches;
  int                checks;

  batt_pack_model i_pack (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_ohms(ohms),
    .i_drive(drv), .o_pins(pins));
  liion_charge_sequencer #(.TICK_CYCLES(TK), .GLITCH_CYCLES(4)) i_dut (.i_clk(clk),
    .i_rst_n(rst_n), .i_pins(pins), .i_bus(bus), .o_rdata(rdata), .o_drive(drv),
    .o_charge_active_n(), .o_charge_active_oe(act_oe), .o_fault_n(), .o_fault_oe(flt_oe),
    .o_supply_present_n(), .o_supply_present_oe(sup_oe));

  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Gap cycle after each strobe so the bus is never assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  function automatic logic cond(input int c);
    case (c)
      0: return drv.out_on;
      1: return !drv.out_on;
      2: return flt_oe;
      default: return act_oe;
    endcase
  endfunction
  // Bounded wait; running out is a failure
  task automatic wait_on(input int c, input int n);
    int i;
    for (i = 0; i < n && cond(c) !== 1'b1; i++)
      @(posedge clk);
    if (i == n)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Read word stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= bus.rd;
    if (rd_d && exp_q.size() > 0)
      cmp_word(rdata & msk_q.pop_front(), exp_q.pop_front());
  end

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    cmd = '0;
    cmd.hot_release = 1'b1;
    cmd.cold_release = 1'b1;
    cmd.cold_dflt_release = 1'b1;
    cmd.cto_grounded = 1'b1;
    cmd.afc_at_vcc = 1'b1;
    cmd.timer_program_pin_at_vcc = 1'b1;
    ohms = 16'h0000;
    bus = '0;
    lfsr = 16'h000F;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(chg_pkg::REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(chg_pkg::REG_LIMIT, 32'h0000_2A30, 32'hFFFF_FFFF);
    lfsr = lfsr_next(lfsr);
    wr(8'h10, {16'h0000, lfsr});  // Unmapped: must be ignored
    rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(chg_pkg::REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    cmd.vcc_uvlo_ok <= 1'b1;
    wait_on(0, 40);
    cmp_flag(drv.pre_current, 1'b1);
    rd(chg_pkg::REG_STATUS, 32'h0000_0011, 32'h0000_0017);
    wait_on(1, 2700 * TK + 50);
    rd(chg_pkg::REG_STATUS, 32'h0000_0045, 32'h0000_0057);
    cmd.bat_above_preq <= 1'b1;
    wait_on(0, 20);
    rd(chg_pkg::REG_STATUS, 32'h0000_0012, 32'h0000_0057);
    cmp_flag(drv.pre_current, 1'b0);
    cmd.hot_trip <= 1'b1;
    cmd.hot_release <= 1'b0;
    wait_on(2, 20);
    cmp_flag(drv.out_on, 1'b0);
    cmd.hot_trip <= 1'b0;  // Inside the hysteresis band
    repeat (12) @(posedge clk);
    cmp_flag(flt_oe, 1'b1);
    cmd.hot_release <= 1'b1;
    wait_on(0, 20);
    rd(chg_pkg::REG_STATUS, 32'h0000_0012, 32'h0000_0037);
    cmd.cold_dflt_trip <= 1'b1;
    cmd.cold_dflt_release <= 1'b0;
    wait_on(2, 20);
    cmd.cold_dflt_trip <= 1'b0;
    cmd.cold_dflt_release <= 1'b1;
    wait_on(0, 20);
    cmd.cto_grounded <= 1'b0;  // Offset input now sets the cold threshold
    cmd.cold_trip <= 1'b1;
    wait_on(2, 20);
    cmd.cold_trip <= 1'b0;
    wait_on(0, 20);
    cmd.bat_at_cv <= 1'b1;
    cmd.iout_above_term <= 1'b1;
    wait_on(3, 20);
    @(posedge clk);  // Voltage loop flag follows the state one cycle later
    cmp_flag(drv.cv_mode, 1'b1);
    cmd.iout_above_term <= 1'b0;
    repeat (12) @(posedge clk);
    cmp_flag(act_oe, 1'b0);
    cmp_flag(drv.out_on, 1'b1);
    wait_on(1, 8100 * TK + 100);
    rd(chg_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0017);
    cmd.bat_below_rechg <= 1'b1;
    wait_on(0, 20);
    cmd.bat_below_rechg <= 1'b0;
    lfsr = lfsr_next(lfsr);
    cmd.vcc_uvlo_ok <= 1'b0;  // Short random dip, under the filter length
    repeat (lfsr[1:0] % 3 + 2) @(posedge clk);
    cmd.vcc_uvlo_ok <= 1'b1;
    repeat (12)
    begin
      @(posedge clk);
      cmp_flag(sup_oe, 1'b1);
    end
    cmd.timer_program_pin_at_vcc <= 1'b0;
    ohms <= 16'h5460;
    cmd.ntc_disable <= 1'b1;
    wait_on(1, 20);
    repeat (10) @(posedge clk);
    cmp_flag(flt_oe, 1'b0);
    cmd.ntc_disable <= 1'b0;
    wait_on(0, 20);
    rd(chg_pkg::REG_LIMIT, 32'h0000_1C20, 32'hFFFF_FFFF);
    cmd.timer_program_pin_at_gnd <= 1'b1;
    cmd.afc_at_vcc <= 1'b0;  // Host now drives the current reference
    cmd.bat_at_cv <= 1'b0;  // Stay in CC until the current has been sensed
    cmd.ntc_disable <= 1'b1;
    wait_on(1, 20);
    cmd.ntc_disable <= 1'b0;
    cmd.iout_above_term <= 1'b1;
    wait_on(3, 40);
    cmd.bat_at_cv <= 1'b1;
    repeat (8) @(posedge clk);
    rd(chg_pkg::REG_STATUS, 32'h0000_0213, 32'h0000_0617);
    cmd.iout_above_term <= 1'b0;
    wait_on(1, 20);
    rd(chg_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0017);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule // liion_charge_sequencer_bench

bind liion_charge_sequencer chg_seq_properties #(.TICK_CYCLES(TICK_CYCLES),
  .GLITCH_CYCLES(GLITCH_CYCLES)) i_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_pins(i_pins), .i_bus(i_bus), .o_rdata(o_rdata), .o_drive(o_drive),
  .o_charge_active_n(o_charge_active_n), .o_charge_active_oe(o_charge_active_oe),
  .o_fault_n(o_fault_n), .o_fault_oe(o_fault_oe), .o_supply_present_n(o_supply_present_n),
  .o_supply_present_oe(o_supply_present_oe));
